// [design/scpc_defines.vh]
// Constants for the speed command and power state control block.
// Assumes the including file works on clk_sys at the rate given here.
`ifndef SCPC_DEFINES_VH
`define SCPC_DEFINES_VH

`define SCPC_CLK_KHZ        20000
`define SCPC_CMD_W          9
`define SCPC_MODE_PWM       2'h0
`define SCPC_MODE_ANALOG    2'h1
`define SCPC_MODE_I2C       2'h2
`define SCPC_STATUS_ADDR    8'h10
`define SCPC_STATUS_LP_BIT  6
`define SCPC_SHADOW_FIRST   8'h20
`define SCPC_SHADOW_LAST    8'h2B
`define SCPC_NVM_BYTES      12
`define SCPC_NVM_BITS       96
`define SCPC_UNLOCK_KEY     8'hB6
`define SCPC_PARAM1_BYTE    0
`define SCPC_PARAM2_BYTE    1
`define SCPC_RM_MIN_VALUE   11'h003
`define SCPC_NVM_WRITE_MS   24
`define SCPC_NVM_WRITE_CYC  (`SCPC_NVM_WRITE_MS * `SCPC_CLK_KHZ)
`define SCPC_LP_TIME_US     1000
`define SCPC_LP_TIME_CYC    ((`SCPC_LP_TIME_US * `SCPC_CLK_KHZ) / 1000)
`define SCPC_V_EN_SB        9'h020
`define SCPC_V_EN_SL        9'h010
`define SCPC_V_EX_SB        9'h030
`define SCPC_V_EX_SL        9'h060
`define SCPC_SINE_STEPS     6'h30
`define SCPC_PHASE_SHIFT    6'h10

`endif

// [design/scpc_code_decode.v]
// Decoder for a mantissa and exponent motor parameter code.
// Assumes a 7-bit code: mantissa in bits 3:0, exponent in bits 6:4.
`timescale 1ns/100ps
`include "scpc_defines.vh"

module scpc_code_decode (
  code,   // Encoded parameter
  value,  // Decoded digital value
  low     // Value below the supported minimum
);
  input  wire [6:0]  code;   // Encoded parameter
  output wire [10:0] value;  // Decoded digital value
  output wire        low;    // Value below the supported minimum

  // Full code 0x7F gives 15 shifted by 7, which is 1920.
  assign value = {7'h00, code[3:0]} << code[6:4];
  assign low   = (value < `SCPC_RM_MIN_VALUE);
endmodule

// [design/scpc_sine_mod.v]
// Three-phase modulator with one phase clamped to ground at any time.
// Assumes the electrical angle is kept in 0 to 47 by the commutation logic.
`timescale 1ns/100ps
`include "scpc_defines.vh"

module scpc_sine_mod (
  clk_sys,  // System clock
  rstn,     // Synchronous reset, active low
  enable,   // Drive enable
  angle,    // Electrical angle step
  duty,     // Peak duty, 511 is full
  pwm_u,    // Phase U gate command
  pwm_v,    // Phase V gate command
  pwm_w     // Phase W gate command
);
  input  wire       clk_sys;  // System clock
  input  wire       rstn;     // Synchronous reset, active low
  input  wire       enable;   // Drive enable
  input  wire [5:0] angle;    // Electrical angle step
  input  wire [8:0] duty;     // Peak duty, 511 is full
  output reg        pwm_u;    // Phase U gate command
  output reg        pwm_v;    // Phase V gate command
  output reg        pwm_w;    // Phase W gate command

  reg  [7:0]  carrier_reg;
  wire [5:0]  ang_v;
  wire [5:0]  ang_w;
  wire [7:0]  s_u;
  wire [7:0]  s_v;
  wire [7:0]  s_w;
  wire [7:0]  s_min;
  wire [16:0] lvl_u;
  wire [16:0] lvl_v;
  wire [16:0] lvl_w;

  function [6:0] quarter;
    input [3:0] i;
    begin
      case (i)
        4'h0: quarter = 7'd0;
        4'h1: quarter = 7'd17;
        4'h2: quarter = 7'd33;
        4'h3: quarter = 7'd49;
        4'h4: quarter = 7'd64;
        4'h5: quarter = 7'd78;
        4'h6: quarter = 7'd90;
        4'h7: quarter = 7'd101;
        4'h8: quarter = 7'd110;
        4'h9: quarter = 7'd117;
        4'hA: quarter = 7'd123;
        4'hB: quarter = 7'd126;
        default: quarter = 7'd127;
      endcase
    end
  endfunction

  function [7:0] sine48;
    input [5:0] a;
    reg   [5:0] t;
    begin
      t = 6'h00;
      if (a < 6'd12) begin
        t = a;
        sine48 = 8'd128 + {1'b0, quarter(t[3:0])};
      end else if (a < 6'd24) begin
        t = 6'd24 - a;
        sine48 = 8'd128 + {1'b0, quarter(t[3:0])};
      end else if (a < 6'd36) begin
        t = a - 6'd24;
        sine48 = 8'd128 - {1'b0, quarter(t[3:0])};
      end else begin
        t = 6'd48 - a;
        sine48 = 8'd128 - {1'b0, quarter(t[3:0])};
      end
    end
  endfunction

  function [5:0] wrap48;
    input [6:0] a;
    begin
      if (a >= {1'b0, `SCPC_SINE_STEPS})
        wrap48 = a[5:0] - `SCPC_SINE_STEPS;
      else
        wrap48 = a[5:0];
    end
  endfunction

  assign ang_v = wrap48({1'b0, angle} + {1'b0, `SCPC_PHASE_SHIFT});
  assign ang_w = wrap48({1'b0, angle} + {`SCPC_PHASE_SHIFT, 1'b0});
  assign s_u   = sine48(angle);
  assign s_v   = sine48(ang_v);
  assign s_w   = sine48(ang_w);
  assign s_min = (s_u < s_v) ? ((s_u < s_w) ? s_u : s_w) : ((s_v < s_w) ? s_v : s_w);
  // clamp lowest phase
  // Removing the common minimum adds the triple harmonic; line voltages stay sine.
  assign lvl_u = (s_u - s_min) * duty;
  assign lvl_v = (s_v - s_min) * duty;
  assign lvl_w = (s_w - s_min) * duty;

  always @(posedge clk_sys) begin
    if (!rstn) begin
      carrier_reg <= 8'h00;
      pwm_u       <= 1'b0;
      pwm_v       <= 1'b0;
      pwm_w       <= 1'b0;
    end else begin
      carrier_reg <= carrier_reg + 8'h01;
      pwm_u <= enable && (lvl_u[16:9] > carrier_reg);
      pwm_v <= enable && (lvl_v[16:9] > carrier_reg);
      pwm_w <= enable && (lvl_w[16:9] > carrier_reg);
    end
  end
endmodule

// [design/scpc_top.v]
// Speed command selection, peak duty, low power states and parameter memory.
// Assumes all control inputs except speed_pin come from logic on clk_sys.
//
// Behaviour
// - Speed command from pin PWM, analog, I2C.
// - Peak duty is command, capped by limiters.
// - Clamp one phase low, modulate other two.
// - Peak duty full scale equals supply amplitude.
// - Low power state stops motor drive.
// - Sleep stops regulator, I2C, clears volatile registers.
// - Standby keeps regulator, registers and I2C.
// - Entry block prevents entry, never forces exit.
// - Status bit 6 set while in low power.
// - Analog level thresholds with hold times.
// - PWM pin low or high for hold times.
// - I2C zero or nonzero command for hold times.
// - Sleep exit in I2C mode by pin only.
// - Ninety-six parameter bits loaded into configuration.
// - Write lasts 24 ms, then start bit clears.
// - Resistance and back-EMF codes are seven bits.
// - Resistance decodes mantissa shifted by exponent.
// - Resistance values below three are unsupported.
// - Back-EMF decodes mantissa shifted by exponent.
`timescale 1ns/100ps
`include "scpc_defines.vh"

module scpc_top #(
  parameter [19:0] T_EN_SB_PWM = `SCPC_LP_TIME_CYC,
  parameter [19:0] T_EN_SL_PWM = `SCPC_LP_TIME_CYC,
  parameter [19:0] T_EX_SB_PWM = `SCPC_LP_TIME_CYC,
  parameter [19:0] T_EX_SL_PWM = `SCPC_LP_TIME_CYC,
  parameter [19:0] T_EN_SB_ANA = `SCPC_LP_TIME_CYC,
  parameter [19:0] T_EN_SL_ANA = `SCPC_LP_TIME_CYC,
  parameter [19:0] T_EX_SB_ANA = `SCPC_LP_TIME_CYC,
  parameter [19:0] T_EX_SL_ANA = `SCPC_LP_TIME_CYC,
  parameter [19:0] T_NVM_WRITE = `SCPC_NVM_WRITE_CYC
) (
  clk_sys,                // System clock, 20 MHz
  rstn,                   // Synchronous reset, active low
  speed_mode,             // Speed command source select
  speed_pin,              // SPEED pin digital level, asynchronous
  speed_pin_analog,       // SPEED pin set up as analog input
  speed_adc,              // SPEED pin analog sample
  speed_command_value,    // Command written over I2C
  supply_surge_limiter,   // Duty cap from supply stabilizing
  accel_limit,            // Duty cap from acceleration current limit
  closed_loop_limit,      // Duty cap from closed loop accelerate
  sleep_variant,          // 1 sleep version, 0 standby version
  low_power_entry_block,  // Blocks entry into low power
  elec_angle,             // Electrical angle from commutation
  shadow_load_select,     // Shadow registers selected for programming
  program_unlock_key,     // Key field of device control register
  nvm_write_request,      // Host writes 1 to write start, pulse
  shadow_params,          // Registers 0x20 to 0x2B, byte 0 at 0x20
  output_peak_duty,       // Applied peak duty
  pwm_u,                  // Phase U gate command
  pwm_v,                  // Phase V gate command
  pwm_w,                  // Phase W gate command
  drive_enable,           // Motor outputs driven
  regulator_enable,       // Step-down regulator on
  i2c_enable,             // I2C interface on
  volatile_clear,         // One-cycle clear of volatile registers
  status_reg,             // Status register at 0x10
  nvm_write_start,        // Write start bit, clears when done
  config_params,          // Parameters loaded from memory
  phase_resistance_value, // Decoded resistance
  bemf_constant_value,    // Decoded back-EMF constant
  resistance_unsupported  // Resistance below supported minimum
);
  input  wire        clk_sys;                 // System clock, 20 MHz
  input  wire        rstn;                    // Synchronous reset, active low
  input  wire [1:0]  speed_mode;              // Speed command source select
  input  wire        speed_pin;               // SPEED pin digital level, asynchronous
  input  wire        speed_pin_analog;        // SPEED pin set up as analog input
  input  wire [8:0]  speed_adc;               // SPEED pin analog sample
  input  wire [8:0]  speed_command_value;     // Command written over I2C
  input  wire [8:0]  supply_surge_limiter;    // Duty cap from supply stabilizing
  input  wire [8:0]  accel_limit;             // Duty cap from acceleration current limit
  input  wire [8:0]  closed_loop_limit;       // Duty cap from closed loop accelerate
  input  wire        sleep_variant;           // 1 sleep version, 0 standby version
  input  wire        low_power_entry_block;   // Blocks entry into low power
  input  wire [5:0]  elec_angle;              // Electrical angle from commutation
  input  wire        shadow_load_select;      // Shadow registers selected for programming
  input  wire [7:0]  program_unlock_key;      // Key field of device control register
  input  wire        nvm_write_request;       // Host writes 1 to write start, pulse
  input  wire [95:0] shadow_params;           // Registers 0x20 to 0x2B, byte 0 at 0x20
  output reg  [8:0]  output_peak_duty;        // Applied peak duty
  output wire        pwm_u;                   // Phase U gate command
  output wire        pwm_v;                   // Phase V gate command
  output wire        pwm_w;                   // Phase W gate command
  output reg         drive_enable;            // Motor outputs driven
  output reg         regulator_enable;        // Step-down regulator on
  output reg         i2c_enable;              // I2C interface on
  output reg         volatile_clear;          // One-cycle clear of volatile registers
  output reg  [7:0]  status_reg;              // Status register at 0x10
  output reg         nvm_write_start;         // Write start bit, clears when done
  output reg  [95:0] config_params;           // Parameters loaded from memory
  output reg  [10:0] phase_resistance_value;  // Decoded resistance
  output reg  [10:0] bemf_constant_value;     // Decoded back-EMF constant
  output reg         resistance_unsupported;  // Resistance below supported minimum

  localparam ST_ACTIVE = 2'b01;
  localparam ST_LOWPWR = 2'b10;

  reg  [1:0]  pin_sync_reg;
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [19:0] hold_cnt_reg;
  reg  [8:0]  win_cnt_reg;
  reg  [8:0]  high_cnt_reg;
  reg  [8:0]  pin_duty_reg;
  reg  [19:0] nvm_cnt_reg;
  reg         load_pending_reg;
  reg  [7:0]  nvm_mem [0:`SCPC_NVM_BYTES-1];
  reg  [8:0]  cmd;
  reg  [8:0]  duty_next;
  reg         cond;
  reg  [19:0] target;
  wire        pin_s;
  wire [10:0] rm_value;
  wire [10:0] kt_value;
  wire        rm_low;
  integer     i;

  function [8:0] min9;
    input [8:0] a;
    input [8:0] b;
    begin
      min9 = (a < b) ? a : b;
    end
  endfunction

  assign pin_s = pin_sync_reg[1];

  always @* begin
    case (speed_mode)
      `SCPC_MODE_PWM:    cmd = pin_duty_reg;
      `SCPC_MODE_ANALOG: cmd = speed_adc;
      `SCPC_MODE_I2C:    cmd = speed_command_value;
      default:           cmd = 9'h000;
    endcase
  end

  always @* begin
    duty_next = min9(min9(cmd, supply_surge_limiter), min9(accel_limit, closed_loop_limit));
    if (state_reg != ST_ACTIVE)
      duty_next = 9'h000;
  end

  // Entry looks at the condition of the fitted variant only, so one counter serves.
  always @* begin
    cond   = 1'b0;
    target = 20'h0_0001;
    if (state_reg == ST_ACTIVE) begin
      case (speed_mode)
        `SCPC_MODE_ANALOG: begin
          cond   = sleep_variant ? (speed_adc < `SCPC_V_EN_SL) : (speed_adc < `SCPC_V_EN_SB);
          target = sleep_variant ? T_EN_SL_ANA : T_EN_SB_ANA;
        end
        `SCPC_MODE_I2C: begin
          cond   = (speed_command_value == 9'h000);
          target = sleep_variant ? T_EN_SL_PWM : T_EN_SB_PWM;
        end
        default: begin
          cond   = !pin_s;
          target = sleep_variant ? T_EN_SL_PWM : T_EN_SB_PWM;
        end
      endcase
      if (low_power_entry_block)
        cond = 1'b0;
    end else begin
      case (speed_mode)
        `SCPC_MODE_ANALOG: begin
          cond   = sleep_variant ? (speed_adc > `SCPC_V_EX_SL) : (speed_adc > `SCPC_V_EX_SB);
          target = sleep_variant ? T_EX_SL_ANA : T_EX_SB_ANA;
        end
        `SCPC_MODE_I2C: begin
          if (sleep_variant) begin
            cond   = speed_pin_analog ? (speed_adc > `SCPC_V_EX_SL) : pin_s;
            target = speed_pin_analog ? T_EX_SL_ANA : T_EX_SL_PWM;
          end else begin
            cond   = (speed_command_value != 9'h000);
            target = T_EX_SB_PWM;
          end
        end
        default: begin
          cond   = pin_s;
          target = sleep_variant ? T_EX_SL_PWM : T_EX_SB_PWM;
        end
      endcase
    end
  end

  always @* begin
    case (state_reg)
      ST_ACTIVE: state_next = (cond && hold_cnt_reg >= target - 20'h0_0001) ? ST_LOWPWR : ST_ACTIVE;
      ST_LOWPWR: state_next = (cond && hold_cnt_reg >= target - 20'h0_0001) ? ST_ACTIVE : ST_LOWPWR;
      default:   state_next = ST_ACTIVE;
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      pin_sync_reg <= 2'b00;
      win_cnt_reg  <= 9'h000;
      high_cnt_reg <= 9'h000;
      pin_duty_reg <= 9'h000;
    end else begin
      pin_sync_reg <= {pin_sync_reg[0], speed_pin};
      // Duty is measured over a fixed 511-cycle window, so slow PWM inputs alias.
      win_cnt_reg  <= (win_cnt_reg == 9'h1FE) ? 9'h000 : win_cnt_reg + 9'h001;
      if (win_cnt_reg == 9'h1FE) begin
        pin_duty_reg <= high_cnt_reg + {8'h00, pin_s};
        high_cnt_reg <= 9'h000;
      end else begin
        high_cnt_reg <= high_cnt_reg + {8'h00, pin_s};
      end
    end
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      state_reg        <= ST_ACTIVE;
      hold_cnt_reg     <= 20'h0_0000;
      output_peak_duty <= 9'h000;
      drive_enable     <= 1'b0;
      regulator_enable <= 1'b1;
      i2c_enable       <= 1'b1;
      volatile_clear   <= 1'b0;
      status_reg       <= 8'h00;
    end else begin
      state_reg <= state_next;
      if (!cond || state_next != state_reg)
        hold_cnt_reg <= 20'h0_0000;
      else if (hold_cnt_reg != 20'hF_FFFF)
        hold_cnt_reg <= hold_cnt_reg + 20'h0_0001;
      output_peak_duty <= duty_next;
      drive_enable     <= (state_next == ST_ACTIVE);
      regulator_enable <= !(sleep_variant && state_next == ST_LOWPWR);
      i2c_enable       <= !(sleep_variant && state_next == ST_LOWPWR);
      volatile_clear   <= sleep_variant && state_reg == ST_ACTIVE && state_next == ST_LOWPWR;
      status_reg <= {1'b0, (state_next == ST_LOWPWR), 6'h00};
    end
  end

  // The memory array is left out of reset: its contents survive power cycles.
  always @(posedge clk_sys) begin
    if (!rstn) begin
      nvm_write_start  <= 1'b0;
      nvm_cnt_reg      <= 20'h0_0000;
      load_pending_reg <= 1'b1;
      config_params    <= 96'h0000_0000_0000_0000_0000_0000;
    end else begin
      if (!nvm_write_start && nvm_write_request && shadow_load_select &&
          program_unlock_key == `SCPC_UNLOCK_KEY) begin
        nvm_write_start <= 1'b1;
        nvm_cnt_reg     <= 20'h0_0000;
      end else if (nvm_write_start) begin
        if (nvm_cnt_reg >= T_NVM_WRITE - 20'h0_0001) begin
          nvm_write_start <= 1'b0;
          for (i = 0; i < `SCPC_NVM_BYTES; i = i + 1)
            nvm_mem[i] <= shadow_params[i*8 +: 8];
        end else begin
          nvm_cnt_reg <= nvm_cnt_reg + 20'h0_0001;
        end
      end
      if (load_pending_reg) begin
        load_pending_reg <= 1'b0;
        for (i = 0; i < `SCPC_NVM_BYTES; i = i + 1)
          config_params[i*8 +: 8] <= nvm_mem[i];
      end else if (sleep_variant && state_reg == ST_LOWPWR && state_next == ST_ACTIVE) begin
        load_pending_reg <= 1'b1;
      end
    end
  end

  scpc_code_decode u_rm_decode (
    .code  (config_params[`SCPC_PARAM1_BYTE*8 +: 7]),
    .value (rm_value),
    .low   (rm_low)
  );

  scpc_code_decode u_kt_decode (
    .code  (config_params[`SCPC_PARAM2_BYTE*8 +: 7]),
    .value (kt_value),
    .low   ()
  );

  always @(posedge clk_sys) begin
    if (!rstn) begin
      phase_resistance_value <= 11'h000;
      bemf_constant_value    <= 11'h000;
      resistance_unsupported <= 1'b0;
    end else begin
      phase_resistance_value <= rm_value;
      bemf_constant_value    <= kt_value;
      resistance_unsupported <= rm_low;
    end
  end

  scpc_sine_mod u_sine_mod (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .enable  (drive_enable),
    .angle   (elec_angle),
    .duty    (output_peak_duty),
    .pwm_u   (pwm_u),
    .pwm_v   (pwm_v),
    .pwm_w   (pwm_w)
  );
endmodule

// [dv/scpc_checker_properties.sv]
// Port checker for the speed command and power state control block.
// Assumes it is bound into scpc_top and sees only that module's ports.
`timescale 1ns/100ps
module scpc_checker_properties #(
  parameter [19:0] T_EN_SB_PWM = 20'h0_0008,
  parameter [19:0] T_EN_SL_PWM = 20'h0_0008,
  parameter [19:0] T_NVM_WRITE = 20'h0_000A
) (
  input wire       clk_sys,               // Clock
  input wire       rstn,                  // Reset
  input wire [1:0] speed_mode,            // Source
  input wire [8:0] speed_command_value,   // Command
  input wire       low_power_entry_block, // Block
  input wire       sleep_variant,         // Variant
  input wire       shadow_load_select,    // Select
  input wire [7:0] program_unlock_key,    // Key
  input wire       nvm_write_request,     // Request
  input wire [8:0] output_peak_duty,      // Duty
  input wire       drive_enable,          // Drive
  input wire       regulator_enable,      // Regulator
  input wire       i2c_enable,            // I2C
  input wire       volatile_clear,        // Clear
  input wire [7:0] status_reg,            // Status
  input wire       nvm_write_start        // Busy
);
  wire        keyed = nvm_write_request && shadow_load_select && program_unlock_key == 8'hB6;
  wire [19:0] lim   = sleep_variant ? T_EN_SL_PWM : T_EN_SB_PWM;
  reg  [19:0] zcnt;
  reg  [19:0] ncnt;

  // Counters stand in for long repetitions.
  always @(posedge clk_sys) begin
    if (!rstn || speed_mode != 2'h2 || speed_command_value != 9'h000 ||
        low_power_entry_block || status_reg[6])
      zcnt <= 20'h0_0000;
    else
      zcnt <= zcnt + 20'h0_0001;
    if (!rstn || !nvm_write_start)
      ncnt <= 20'h0_0000;
    else
      ncnt <= ncnt + 20'h0_0001;
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  a_lp_stops_drive: assert property (status_reg[6] |-> !drive_enable)
    else $error("drive on in low power");
  a_lp_duty_zero: assert property ($past(status_reg[6]) && status_reg[6] |->
    output_peak_duty == 9'h000) else $error("duty not zero in low power");
  a_standby_on: assert property (!sleep_variant |-> regulator_enable && i2c_enable)
    else $error("standby variant turned supply off");
  a_sleep_off: assert property (sleep_variant && status_reg[6] |->
    !regulator_enable && !i2c_enable) else $error("sleep left supply on");
  a_sleep_clears: assert property ($rose(status_reg[6]) && sleep_variant |->
    ##[0:1] volatile_clear) else $error("no clear on sleep entry");
  a_block_holds: assert property (low_power_entry_block && !status_reg[6] |=>
    !status_reg[6]) else $error("entry while blocked");
  a_entry_time: assert property (zcnt == lim |-> status_reg[6])
    else $error("late low power entry");
  a_entry_early: assert property ($rose(status_reg[6]) && speed_mode == 2'h2 |->
    zcnt == lim) else $error("early low power entry");
  a_nvm_keyed: assert property ($rose(nvm_write_start) |-> $past(keyed))
    else $error("write started without key");
  a_nvm_length: assert property ($fell(nvm_write_start) |-> ncnt == T_NVM_WRITE)
    else $error("bad write length");

  c_enter: cover property ($rose(status_reg[6]));
  c_clear: cover property (volatile_clear);
  c_write: cover property ($fell(nvm_write_start));
endmodule

bind scpc_top scpc_checker_properties #(.T_EN_SB_PWM(T_EN_SB_PWM), .T_EN_SL_PWM(T_EN_SL_PWM),
  .T_NVM_WRITE(T_NVM_WRITE)) chk_u (.clk_sys, .rstn, .speed_mode, .speed_command_value,
  .low_power_entry_block, .sleep_variant, .shadow_load_select, .program_unlock_key,
  .nvm_write_request, .output_peak_duty, .drive_enable, .regulator_enable, .i2c_enable,
  .volatile_clear, .status_reg, .nvm_write_start);

// [dv/scpc_host_model.sv]
// Host model that fills the shadow registers and starts a memory write.
// Assumes the bench calls program_nvm from its main sequence.
`timescale 1ns/100ps
module scpc_host_model (
  input wire        clk_sys,            // Clock
  output reg        shadow_load_select = 1'b0, // Select
  output reg [7:0]  program_unlock_key = 8'h00, // Key
  output reg        nvm_write_request = 1'b0, // Start pulse
  output reg [95:0] shadow_params = 96'h0 // Shadow image
);
  task automatic program_nvm(input logic [7:0] key, input logic [95:0] image, input int gap);
    @(posedge clk_sys);
    shadow_load_select <= 1'b1;
    shadow_params <= image;
    @(posedge clk_sys);
    program_unlock_key <= key;
    repeat (gap + 1) @(posedge clk_sys);
    nvm_write_request <= 1'b1;
    @(posedge clk_sys);
    nvm_write_request <= 1'b0;
    shadow_load_select <= 1'b0;
    program_unlock_key <= 8'h00;
  endtask
endmodule

// [dv/test_speed_command_power_state_control.sv]
// Self-checking bench for the speed command and power state control block.
// Assumes short hold and write counts so the whole run stays brief.
`timescale 1ns/100ps
module test_speed_command_power_state_control;
  localparam int T = 8;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        speed_pin = 1'b0;
  logic        speed_pin_analog = 1'b0;
  logic        sleep_variant = 1'b0;
  logic        low_power_entry_block = 1'b0;
  logic [1:0]  speed_mode = 2'h2;
  logic [8:0]  speed_adc = 9'h150;
  logic [8:0]  speed_command_value = 9'h100;
  logic [26:0] caps = {3{9'h1FF}};
  logic [5:0]  elec_angle = 6'h00;
  wire  [8:0]  output_peak_duty;
  wire  [7:0]  status_reg, program_unlock_key;
  wire  [95:0] config_params, shadow_params;
  wire  [10:0] phase_resistance_value, bemf_constant_value;
  wire         drive_enable, regulator_enable, i2c_enable, nvm_write_start, pwm_u, pwm_v, pwm_w;
  wire         resistance_unsupported, shadow_load_select, nvm_write_request;
  int          mismatches = 0;
  int          comparisons = 0;
  integer      i;

  initial forever #25 clk_sys = ~clk_sys;

  always @(posedge clk_sys)
    elec_angle <= (elec_angle == 6'h2F) ? 6'h00 : elec_angle + 6'h01;

  scpc_host_model host_u (.clk_sys, .shadow_load_select, .program_unlock_key,
    .nvm_write_request, .shadow_params);

  scpc_top #(.T_EN_SB_PWM(T), .T_EN_SL_PWM(T), .T_EX_SB_PWM(T), .T_EX_SL_PWM(T),
    .T_EN_SB_ANA(T), .T_EN_SL_ANA(T), .T_EX_SB_ANA(T), .T_EX_SL_ANA(T), .T_NVM_WRITE(10))
  dut_u (.clk_sys, .rstn, .speed_mode, .speed_pin, .speed_pin_analog, .speed_adc,
    .speed_command_value, .supply_surge_limiter(caps[26:18]), .accel_limit(caps[17:9]),
    .closed_loop_limit(caps[8:0]), .sleep_variant, .low_power_entry_block, .elec_angle,
    .shadow_load_select, .program_unlock_key, .nvm_write_request, .shadow_params,
    .output_peak_duty, .pwm_u, .pwm_v, .pwm_w, .drive_enable, .regulator_enable, .i2c_enable,
    .volatile_clear(), .status_reg, .nvm_write_start, .config_params, .phase_resistance_value,
    .bemf_constant_value, .resistance_unsupported);

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic do_reset(input logic variant);
    @(posedge clk_sys);
    rstn <= 1'b0;
    sleep_variant <= variant;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    step(3);
  endtask

  task automatic t_duty;
    logic [8:0] lim;
    for (i = 0; i < 3; i++) begin
      lim = 9'h0A5 + 9'(i);
      @(posedge clk_sys);
      caps <= ~({18'h0_0000, ~lim} << 9 * i);
      step(2);
      chk(output_peak_duty, lim);
    end
    @(posedge clk_sys);
    caps <= {3{9'h1FF}};
    step(2);
    chk(output_peak_duty, 9'h100);
    @(posedge clk_sys);
    speed_mode <= 2'h1;
    step(2);
    chk(output_peak_duty, 9'h150);
    @(posedge clk_sys);
    speed_mode <= 2'h0;
    speed_pin <= 1'b1;
    step(1100);
    chk(output_peak_duty, 9'h1FF);
    $display("t_duty done");
  endtask

  task automatic t_standby;
    @(posedge clk_sys);
    speed_mode <= 2'h2;
    low_power_entry_block <= 1'b1;
    speed_command_value <= 9'h000;
    step(T + 4);
    chk(status_reg, 8'h00);
    @(posedge clk_sys);
    speed_command_value <= 9'h080;
    @(posedge clk_sys);
    low_power_entry_block <= 1'b0;
    speed_command_value <= 9'h000;
    step(T - 1);
    chk(status_reg, 8'h00);
    step(3);
    chk({status_reg, drive_enable, regulator_enable, i2c_enable, pwm_u, pwm_v, pwm_w},
        {8'h40, 6'b011000});
    @(posedge clk_sys);
    low_power_entry_block <= 1'b1;
    step(T + 4);
    chk(status_reg, 8'h40);
    @(posedge clk_sys);
    low_power_entry_block <= 1'b0;
    speed_command_value <= 9'h080;
    step(T + 3);
    chk({status_reg, drive_enable}, {8'h00, 1'b1});
    $display("t_standby done");
  endtask

  task automatic t_pin_modes;
    @(posedge clk_sys);
    speed_mode <= 2'h1;
    speed_adc <= 9'h01F;
    step(T + 3);
    chk(status_reg, 8'h40);
    @(posedge clk_sys);
    speed_adc <= 9'h030;
    step(T + 4);
    chk(status_reg, 8'h40);
    @(posedge clk_sys);
    speed_adc <= 9'h031;
    step(T + 3);
    chk(status_reg, 8'h00);
    @(posedge clk_sys);
    speed_mode <= 2'h0;
    speed_pin <= 1'b0;
    step(T + 5);
    chk(status_reg, 8'h40);
    @(posedge clk_sys);
    speed_pin <= 1'b1;
    step(T + 5);
    chk(status_reg, 8'h00);
    $display("t_pin_modes done");
  endtask

  task automatic t_nvm;
    host_u.program_nvm(8'hB5, 96'h7F02, 0);
    step(1);
    chk(nvm_write_start, 1'b0);
    host_u.program_nvm(8'hB6, 96'h7F02, 3);
    step(1);
    chk(nvm_write_start, 1'b1);
    step(12);
    chk(nvm_write_start, 1'b0);
    do_reset(1'b1);
    chk(config_params[15:0], 16'h7F02);
    chk({resistance_unsupported, phase_resistance_value}, {1'b1, 11'h002});
    chk(bemf_constant_value, 11'h780);
    $display("t_nvm done");
  endtask

  task automatic t_sleep;
    @(posedge clk_sys);
    speed_mode <= 2'h2;
    // pin held at a defined low
    speed_pin <= 1'b0;
    speed_command_value <= 9'h000;
    step(T + 3);
    chk({status_reg, drive_enable, regulator_enable, i2c_enable}, {8'h40, 3'b000});
    @(posedge clk_sys);
    speed_command_value <= 9'h080;
    speed_pin_analog <= 1'b1;
    speed_pin <= 1'b1;
    step(T + 4);
    chk(status_reg, 8'h40);
    @(posedge clk_sys);
    speed_pin_analog <= 1'b0;
    step(T + 6);
    chk({status_reg, regulator_enable, i2c_enable}, {8'h00, 2'b11});
    step(2);
    chk(config_params[15:0], 16'h7F02);
    $display("t_sleep done");
  endtask

  task automatic close_out;
    $display("TB: comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    do_reset(1'b0);
    chk({status_reg, regulator_enable, i2c_enable, drive_enable}, {8'h00, 3'b111});
    t_duty;
    t_standby;
    t_pin_modes;
    t_nvm;
    t_sleep;
    close_out;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    close_out;
  end
endmodule
